//--- hw/tcsp_debounce.sv
// One active-low pin: two-flop synchroniser, then a run-length filter
module tcsp_debounce #(
  parameter logic [23:0] DEB_CYCLES = tcsp_pkg::TCSP_DEB_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin, active low
  input wire logic pin_n,
  // Filtered level, high = asserted
  output logic level,
  output logic primed
);

  tcsp_pkg::tcsp_deb_type s_r;
  tcsp_pkg::tcsp_deb_type s_nxt;

  // Only sync2 is looked at; sync1 may be metastable
  always_comb
  begin
    logic samp;
    samp = ~s_r.sync2;
    s_nxt = s_r;
    s_nxt.sync1 = pin_n;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.last = samp;
    if (samp != s_r.last)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt != DEB_CYCLES - 24'h000001)
    begin
      s_nxt.cnt = s_r.cnt + 24'h000001;
    end
    else
    begin
      // Held for the full minimum width: accept it
      s_nxt.level = samp;
      s_nxt.primed = 1'b1;
    end
  end

  // Pins idle high, so reset to the inactive level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '{sync1: 1'b1, sync2: 1'b1, last: 1'b0, level: 1'b0, primed: 1'b0, cnt: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;
  assign primed = s_r.primed;

endmodule

//--- hw/tcsp_port.sv
// Functional notes
// - Every control input is active low; open or high means inactive.
// - Select bits 0..3 are units digit, bits 4..7 tens digit, BCD active low.
// - Select is captured at strobe rising edge and recalls that number; the code does so in ready state only.
// - Test-active stays on for the whole test, ramp-up included.
// - Pass output is on for at least 0.2 s after a pass judgement; the code drops it early if a new start comes first.
// - With pass hold enabled, pass output stays on continuously.
// - Upper-fail stays on while an at-or-above-upper failure is held.
// - Lower-fail stays on while an at-or-below-lower failure is held.
// - Ready output is on while the tester waits in ready state.
// - Protection output is on whenever protection state is entered.
// - A valid start assertion requests a test like the panel start switch.
// - A valid stop assertion requests a stop like the panel stop switch.
// - Remote jack start and stop merge with the front panel switches.
// - Ready drops once a valid start pulse is detected.
// - Enable low: port and jack start honoured, panel start ignored.
// - Any enable level change trips protection; only stop clears it.
//
// Local design decisions: the register offsets and the APB interface to the registers.
module tcsp_port #(
  parameter logic [23:0] DEB_CYCLES = tcsp_pkg::TCSP_DEB_CYCLES,
  parameter logic [23:0] PASS_CYCLES = tcsp_pkg::TCSP_PASS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Connector and remote jack pins, active low
  input wire tcsp_pkg::tcsp_pins_type pins,
  // Status lines to the open-collector drivers, high = ON
  output tcsp_pkg::tcsp_lines_type lines,
  // Measurement core
  input wire tcsp_pkg::tcsp_judge_type judge,
  input wire logic core_trip,
  output tcsp_pkg::tcsp_core_type core_req
);

  typedef struct packed {
    tcsp_pkg::tcsp_fsm_type fsm;
    tcsp_pkg::tcsp_inputs_type prev;
    logic armed;
    logic enable_ref;
    logic [23:0] pass_cnt;
    logic pass_hold;
    logic sw_start;
    logic sw_stop;
    logic [6:0] sel_num;
    logic sel_bad;
    logic [1:0] prot_cause;
    logic [15:0] test_count;
    tcsp_pkg::tcsp_lines_type lines;
    tcsp_pkg::tcsp_core_type core;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcsp_state_type;

  tcsp_state_type s_r;
  tcsp_state_type s_nxt;
  logic [tcsp_pkg::TCSP_PIN_W-1:0] pin_vec;
  logic [tcsp_pkg::TCSP_PIN_W-1:0] lvl_vec;
  logic [tcsp_pkg::TCSP_PIN_W-1:0] primed_vec;
  tcsp_pkg::tcsp_inputs_type deb;
  logic all_primed;

  // Merged start request: enable selects port side or panel side
  function automatic logic start_src(input tcsp_pkg::tcsp_inputs_type in);
    if (in.enable)
    begin
      start_src = in.start | in.remote_start;
    end
    else
    begin
      start_src = in.panel_start | in.remote_start;
    end
  endfunction

  // Any stop source stops the tester
  function automatic logic stop_src(input tcsp_pkg::tcsp_inputs_type in);
    stop_src = in.stop | in.remote_stop | in.panel_stop;
  endfunction

  // Two BCD digits to binary; top bit flags a legal code
  function automatic logic [7:0] bcd_decode(input logic [7:0] sel);
    logic [3:0] units;
    logic [3:0] tens;
    units = sel[3:0];
    tens = sel[7:4];
    bcd_decode[7] = (units <= 4'h9) && (tens <= 4'h9);
    bcd_decode[6:0] = 7'(tens) * 7'h0a + 7'(units);
  endfunction

  // Register read mux
  function automatic logic [31:0] read_reg(input logic [11:0] addr, input tcsp_state_type s);
    read_reg = '0;
    case (addr)
      tcsp_pkg::TCSP_CTRL_OFS:
      begin
        read_reg[tcsp_pkg::TCSP_CTRL_HOLD_BIT] = s.pass_hold;
      end
      tcsp_pkg::TCSP_STATUS_OFS:
      begin
        read_reg[1:0] = s.fsm;
        read_reg[tcsp_pkg::TCSP_STAT_LINES_POS +: 6] = s.lines;
        read_reg[tcsp_pkg::TCSP_STAT_ENABLE_BIT] = s.enable_ref;
        read_reg[tcsp_pkg::TCSP_STAT_ARMED_BIT] = s.armed;
      end
      tcsp_pkg::TCSP_SELECT_OFS:
      begin
        read_reg[6:0] = s.sel_num;
        read_reg[tcsp_pkg::TCSP_SEL_BAD_BIT] = s.sel_bad;
      end
      tcsp_pkg::TCSP_PROTECT_OFS:
      begin
        read_reg[1:0] = s.prot_cause;
      end
      tcsp_pkg::TCSP_INPUTS_OFS:
      begin
        read_reg[15:0] = s.prev;
      end
      tcsp_pkg::TCSP_COUNT_OFS:
      begin
        read_reg[15:0] = s.test_count;
      end
      default:
      begin
        read_reg = '0;
      end
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    case (addr)
      tcsp_pkg::TCSP_CTRL_OFS, tcsp_pkg::TCSP_STATUS_OFS, tcsp_pkg::TCSP_SELECT_OFS,
      tcsp_pkg::TCSP_PROTECT_OFS, tcsp_pkg::TCSP_INPUTS_OFS, tcsp_pkg::TCSP_COUNT_OFS:
      begin
        addr_mapped = 1'b1;
      end
      default:
      begin
        addr_mapped = 1'b0;
      end
    endcase
  endfunction

  // Every pin gets its own filter so one bouncing line cannot hold back another
  assign pin_vec = pins;

  genvar gi;
  generate
    for (gi = 0; gi < tcsp_pkg::TCSP_PIN_W; gi++)
    begin : g_deb
      tcsp_debounce #(
        .DEB_CYCLES(DEB_CYCLES)
      ) u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(pin_vec[gi]),
        .level(lvl_vec[gi]),
        .primed(primed_vec[gi])
      );
    end
  endgenerate

  assign deb = lvl_vec;
  assign all_primed = &primed_vec;

  // Next-state logic for the whole port
  always_comb
  begin
    logic start_edge;
    logic stop_edge;
    logic strobe_rise;
    logic [7:0] dec;
    logic setup;
    logic wr;
    start_edge = 1'b0;
    stop_edge = 1'b0;
    strobe_rise = 1'b0;
    dec = '0;
    setup = 1'b0;
    wr = 1'b0;
    s_nxt = s_r;
    s_nxt.prev = deb;
    s_nxt.sw_start = 1'b0;
    s_nxt.sw_stop = 1'b0;
    s_nxt.core.start_req = 1'b0;
    s_nxt.core.stop_req = 1'b0;
    s_nxt.core.recall_req = 1'b0;

    // Edges only count once the filters have settled after reset
    start_edge = s_r.armed & start_src(deb) & ~start_src(s_r.prev);
    start_edge = start_edge | s_r.sw_start;
    stop_edge = s_r.armed & stop_src(deb) & ~stop_src(s_r.prev);
    stop_edge = stop_edge | s_r.sw_stop;
    // Pin going high is the filtered level falling
    strobe_rise = s_r.armed & s_r.prev.select_strobe & ~deb.select_strobe;
    dec = bcd_decode(deb.select);

    // APB write takes effect at the access edge
    setup = psel & ~penable;
    wr = psel & penable & pwrite & s_r.pready;
    if (wr)
    begin
      case (paddr)
        tcsp_pkg::TCSP_CTRL_OFS:
        begin
          s_nxt.pass_hold = pwdata[tcsp_pkg::TCSP_CTRL_HOLD_BIT];
          s_nxt.sw_start = pwdata[tcsp_pkg::TCSP_CTRL_START_BIT];
          s_nxt.sw_stop = pwdata[tcsp_pkg::TCSP_CTRL_STOP_BIT];
        end
        tcsp_pkg::TCSP_SELECT_OFS:
        begin
          if (pwdata[tcsp_pkg::TCSP_SEL_BAD_BIT])
          begin
            s_nxt.sel_bad = 1'b0;  // Write one to clear
          end
        end
        default:
        begin
          s_nxt.sel_bad = s_nxt.sel_bad;
        end
      endcase
    end
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~addr_mapped(paddr);
    s_nxt.prdata = setup ? read_reg(paddr, s_r) : s_r.prdata;

    // Pass line timing: counts down, then drops unless held
    if (s_r.pass_cnt != 24'h000000)
    begin
      s_nxt.pass_cnt = s_r.pass_cnt - 24'h000001;
    end
    else if (!s_r.pass_hold)
    begin
      s_nxt.lines.pass = 1'b0;
    end

    // Stop from any source goes to the core
    s_nxt.core.stop_req = stop_edge;

    // Tester sequence
    case (s_r.fsm)
      tcsp_pkg::TCSP_READY:
      begin
        if (start_edge && !stop_edge)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_TEST;
          s_nxt.core.start_req = 1'b1;
          s_nxt.lines.pass = 1'b0;
          s_nxt.pass_cnt = '0;
          s_nxt.test_count = s_r.test_count + 16'h0001;
        end
      end
      tcsp_pkg::TCSP_TEST:
      begin
        if (stop_edge)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_READY;
        end
        else if (judge.valid && judge.pass)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_READY;
          s_nxt.lines.pass = 1'b1;
          s_nxt.pass_cnt = PASS_CYCLES;
        end
        else if (judge.valid)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_FAIL;
          s_nxt.lines.upper_fail = judge.upper;
          s_nxt.lines.lower_fail = judge.lower;
        end
      end
      tcsp_pkg::TCSP_FAIL:
      begin
        // Fail lines hold until the operator stops
        if (stop_edge)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_READY;
          s_nxt.lines.upper_fail = 1'b0;
          s_nxt.lines.lower_fail = 1'b0;
        end
      end
      tcsp_pkg::TCSP_PROTECT:
      begin
        if (stop_edge)
        begin
          s_nxt.fsm = tcsp_pkg::TCSP_READY;
          s_nxt.prot_cause = '0;
        end
      end
      default:
      begin
        s_nxt.fsm = tcsp_pkg::TCSP_READY;
      end
    endcase

    // Recall only from ready; an illegal digit leaves the selection alone
    if (strobe_rise && s_r.fsm == tcsp_pkg::TCSP_READY)
    begin
      if (dec[7])
      begin
        s_nxt.sel_num = dec[6:0];
        s_nxt.core.recall_req = 1'b1;
        s_nxt.core.recall_num = dec[6:0];
      end
      else
      begin
        s_nxt.sel_bad = 1'b1;
      end
    end

    // Protection is decided last so a trip outranks a stop in the same cycle
    if (!s_r.armed)
    begin
      if (all_primed)
      begin
        // First settled level is the reference, not a change
        s_nxt.armed = 1'b1;
        s_nxt.enable_ref = deb.enable;
      end
    end
    else if (deb.enable != s_r.enable_ref)
    begin
      s_nxt.enable_ref = deb.enable;
      s_nxt.prot_cause[tcsp_pkg::TCSP_PROT_ENABLE_BIT] = 1'b1;
      s_nxt.fsm = tcsp_pkg::TCSP_PROTECT;
    end
    if (core_trip)
    begin
      s_nxt.prot_cause[tcsp_pkg::TCSP_PROT_TRIP_BIT] = 1'b1;
      s_nxt.fsm = tcsp_pkg::TCSP_PROTECT;
    end
    if (s_nxt.fsm == tcsp_pkg::TCSP_PROTECT)
    begin
      s_nxt.core.start_req = 1'b0;
    end

    // State-derived lines, registered with the state itself
    s_nxt.lines.test_active = (s_nxt.fsm == tcsp_pkg::TCSP_TEST);
    s_nxt.lines.ready = (s_nxt.fsm == tcsp_pkg::TCSP_READY);
    s_nxt.lines.protect = (s_nxt.fsm == tcsp_pkg::TCSP_PROTECT);
  end

  // All port state in one register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.fsm <= tcsp_pkg::TCSP_READY;
      s_r.pass_hold <= tcsp_pkg::TCSP_PASS_HOLD_RST;
      s_r.sel_num <= tcsp_pkg::TCSP_SEL_RST;
      s_r.test_count <= tcsp_pkg::TCSP_COUNT_RST;
      s_r.lines.ready <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign lines = s_r.lines;
  assign core_req = s_r.core;

endmodule

//--- pkg/tcsp_pkg.sv
package tcsp_pkg;

  // Clock rate and documented times
  localparam int TCSP_CLK_KHZ = 50_000;
  localparam int TCSP_MIN_PULSE_MS = 5;
  localparam int TCSP_PASS_MS = 200;
  localparam int TCSP_CNT_W = 24;

  // Least times round up; both are exact at this clock rate
  localparam logic [23:0] TCSP_DEB_CYCLES = 24'(TCSP_MIN_PULSE_MS * TCSP_CLK_KHZ);
  localparam logic [23:0] TCSP_PASS_CYCLES = 24'(TCSP_PASS_MS * TCSP_CLK_KHZ);

  // APB register map, byte addresses
  localparam int TCSP_ADDR_W = 12;
  localparam logic [11:0] TCSP_CTRL_OFS = 12'h000;
  localparam logic [11:0] TCSP_STATUS_OFS = 12'h004;
  localparam logic [11:0] TCSP_SELECT_OFS = 12'h008;
  localparam logic [11:0] TCSP_PROTECT_OFS = 12'h00c;
  localparam logic [11:0] TCSP_INPUTS_OFS = 12'h010;
  localparam logic [11:0] TCSP_COUNT_OFS = 12'h014;

  // Field positions
  localparam int TCSP_CTRL_HOLD_BIT = 0;
  localparam int TCSP_CTRL_START_BIT = 1;
  localparam int TCSP_CTRL_STOP_BIT = 2;
  localparam int TCSP_SEL_BAD_BIT = 8;
  localparam int TCSP_PROT_ENABLE_BIT = 0;
  localparam int TCSP_PROT_TRIP_BIT = 1;
  localparam int TCSP_STAT_LINES_POS = 2;
  localparam int TCSP_STAT_ENABLE_BIT = 8;
  localparam int TCSP_STAT_ARMED_BIT = 9;

  // Values after reset
  localparam logic TCSP_PASS_HOLD_RST = 1'b0;
  localparam logic [6:0] TCSP_SEL_RST = 7'h00;
  localparam logic [15:0] TCSP_COUNT_RST = 16'h0000;

  // Number of connector and jack pins
  localparam int TCSP_PIN_W = 16;

  // Raw pins, active low
  typedef struct packed {
    logic [7:0] select_n;
    logic select_strobe_n;
    logic start_n;
    logic stop_n;
    logic enable_n;
    logic remote_start_n;
    logic remote_stop_n;
    logic panel_start_n;
    logic panel_stop_n;
  } tcsp_pins_type;

  // Debounced inputs, high = asserted
  typedef struct packed {
    logic [7:0] select;
    logic select_strobe;
    logic start;
    logic stop;
    logic enable;
    logic remote_start;
    logic remote_stop;
    logic panel_start;
    logic panel_stop;
  } tcsp_inputs_type;

  // Status lines, high = ON
  typedef struct packed {
    logic test_active;
    logic pass;
    logic upper_fail;
    logic lower_fail;
    logic ready;
    logic protect;
  } tcsp_lines_type;

  // Judgement from the measurement core
  typedef struct packed {
    logic valid;
    logic pass;
    logic upper;
    logic lower;
  } tcsp_judge_type;

  // Requests to the measurement core
  typedef struct packed {
    logic start_req;
    logic stop_req;
    logic recall_req;
    logic [6:0] recall_num;
  } tcsp_core_type;

  typedef enum logic [1:0] {TCSP_READY, TCSP_TEST, TCSP_FAIL, TCSP_PROTECT} tcsp_fsm_type;

  // Debouncer state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic level;
    logic primed;
    logic [23:0] cnt;
  } tcsp_deb_type;

endpackage

//--- verif/tcsp_ctrl_model.sv
// Far-side controller: drives the active-low pins, holding each pulse past the filter
module tcsp_ctrl_model #(
  parameter int HOLD = 12
) (
  // Clock
  input wire logic pclk,
  // Connector and jack pins, active low
  output tcsp_pkg::tcsp_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released pins read high through the pull-up; enable goes low before any start
  initial
  begin
    pins = '1;
    pins.enable_n = 1'b0;
  end

  // Hold a pin low longer than the filter, then release it for as long
  task automatic pulse(input int idx);
    @(posedge pclk);
    pins[idx] <= 1'b0;
    repeat (HOLD) @(posedge pclk);
    pins[idx] <= 1'b1;
    repeat (HOLD) @(posedge pclk);
  endtask

  // Two BCD digits, a low pin is a one
  task automatic put_select(input logic [7:0] bcd);
    @(posedge pclk);
    pins.select_n <= ~bcd;
  endtask

  // Any flip of this level trips the far end, so the bench calls it on purpose only
  task automatic set_enable(input logic on);
    @(posedge pclk);
    pins.enable_n <= ~on;
  endtask
endmodule

//--- verif/tcsp_port_props.sv
// Checker on the status lines and core requests
module tcsp_port_props #(
  parameter logic [23:0] PASS_CYCLES = tcsp_pkg::TCSP_PASS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Status lines and core side
  input wire tcsp_pkg::tcsp_lines_type lines,
  input wire tcsp_pkg::tcsp_judge_type judge,
  input wire logic core_trip,
  input wire tcsp_pkg::tcsp_core_type core_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [23:0] pass_run_r;
  logic [23:0] pass_run_nxt;
  // Length of the present pass pulse; too long to unroll as a repetition
  always_comb pass_run_nxt = lines.pass ? pass_run_r + 24'h000001 : 24'h000000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pass_run_r <= 24'h000000;
    else pass_run_r <= pass_run_nxt;

  property p_start_leaves_ready;
    core_req.start_req |-> lines.test_active && !lines.ready;
  endproperty
  a_start_leaves_ready: assert property (p_start_leaves_ready)
    else $error("start request without test state");
  property p_active_not_ready;
    lines.test_active |-> !lines.ready;
  endproperty
  a_active_not_ready: assert property (p_active_not_ready)
    else $error("ready during test");
  property p_pass_ends_test;
    judge.valid && judge.pass && lines.test_active && !core_trip
      |=> lines.pass && lines.ready && !lines.test_active;
  endproperty
  a_pass_ends_test: assert property (p_pass_ends_test)
    else $error("pass judgement not shown");
  property p_upper_fail;
    judge.valid && !judge.pass && judge.upper && lines.test_active && !core_trip
      |=> lines.upper_fail && !lines.ready;
  endproperty
  a_upper_fail: assert property (p_upper_fail)
    else $error("upper fail not shown");
  property p_lower_fail;
    judge.valid && !judge.pass && judge.lower && lines.test_active && !core_trip
      |=> lines.lower_fail && !lines.ready;
  endproperty
  a_lower_fail: assert property (p_lower_fail)
    else $error("lower fail not shown");
  property p_fail_holds;
    (lines.upper_fail || lines.lower_fail) && !core_req.stop_req
      |=> lines.upper_fail || lines.lower_fail || core_req.stop_req;
  endproperty
  a_fail_holds: assert property (p_fail_holds)
    else $error("fail line dropped without stop");
  property p_pass_width;
    $fell(lines.pass) |-> pass_run_r >= PASS_CYCLES;
  endproperty
  a_pass_width: assert property (p_pass_width)
    else $error("pass pulse too short");
  property p_trip_protect;
    core_trip |-> ##[1:2] lines.protect;
  endproperty
  a_trip_protect: assert property (p_trip_protect)
    else $error("trip did not raise protection");
  property p_protect_holds;
    lines.protect && !core_req.stop_req |=> lines.protect || core_req.stop_req;
  endproperty
  a_protect_holds: assert property (p_protect_holds)
    else $error("protection cleared without stop");
  property p_recall_only;
    $changed(core_req.recall_num) |-> core_req.recall_req && core_req.recall_num <= 7'h63;
  endproperty
  a_recall_only: assert property (p_recall_only)
    else $error("selection changed without recall");
  property p_apb_zero_wait;
    psel && !penable |=> pready;
  endproperty
  a_apb_zero_wait: assert property (p_apb_zero_wait)
    else $error("apb answer late");

  // Main scenarios reached
  c_pass: cover property ($fell(lines.pass));
  c_upper: cover property ($rose(lines.upper_fail));
  c_protect: cover property ($rose(lines.protect));
  c_recall: cover property (core_req.recall_req);
endmodule

bind tcsp_port tcsp_port_props #(.PASS_CYCLES(PASS_CYCLES)) i_tcsp_port_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .lines(lines), .judge(judge), .core_trip(core_trip), .core_req(core_req));

//--- verif/test_control_signal_port_tb.sv
module test_control_signal_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened filter and pass times keep the run brief
  localparam logic [23:0] DEB = 24'h000008;
  localparam logic [23:0] PASSC = 24'h000014;
  localparam int ACT = 5, PAS = 4, UPF = 3, LOF = 2, RDY = 1, PRT = 0;
  localparam int STB = 7, STA = 6, STO = 5, RSTA = 3, RSTO = 2, PSTA = 1, PSTO = 0;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tcsp_pkg::tcsp_pins_type pins;
  tcsp_pkg::tcsp_lines_type lines;
  tcsp_pkg::tcsp_judge_type judge = '0;
  logic core_trip = 1'b0;
  tcsp_pkg::tcsp_core_type core_req;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int rec_cnt = 0;
  int n;
  logic [6:0] rec_num = 7'h00;
  logic [31:0] rd;
  logic err;

  // Clock, 20 ns period
  always #10 pclk = ~pclk;

  tcsp_port #(.DEB_CYCLES(DEB), .PASS_CYCLES(PASSC)) i_tcsp_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .lines(lines), .judge(judge), .core_trip(core_trip), .core_req(core_req));
  // Release time must cover sync, filter, recall register and the monitor flop
  tcsp_ctrl_model #(.HOLD(16)) i_tcsp_ctrl_model (.pclk(pclk), .pins(pins));

  // Recall requests seen by the core; hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (core_req.recall_req === 1'b1)
    begin
      rec_cnt <= rec_cnt + 1;
      rec_num <= core_req.recall_num;
    end
    if (cycles == 10000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle judgement from the core
  task automatic judge_out(input logic p, input logic up, input logic lo);
    @(posedge pclk);
    judge <= {1'b1, p, up, lo};
    @(posedge pclk);
    judge <= '0;
    @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h5341d009));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tcsp_pkg::TCSP_SELECT_OFS, 32'h0);
    chk("select reset", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    do apb(1'b0, tcsp_pkg::TCSP_STATUS_OFS, 32'h0); while (rd[9] !== 1'b1);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 99 : (i == 1) ? 0 : $urandom_range(99);
      i_tcsp_ctrl_model.put_select(bcd(n));
      i_tcsp_ctrl_model.pulse(STB);
      chk("recall", 32'(n), 32'(rec_num));
    end
    n = rec_cnt;
    i_tcsp_ctrl_model.put_select(8'ha3);
    i_tcsp_ctrl_model.pulse(STB);
    chk("bad bcd recall", 32'(n), 32'(rec_cnt));
    $display("test recall done");
    i_tcsp_ctrl_model.pulse(STA);
    chk("port start", 32'h1, 32'({lines[ACT], lines[RDY]} == 2'b10));
    repeat ($urandom_range(6)) @(posedge pclk);
    judge_out(1'b1, 1'b0, 1'b0);
    chk("pass", 32'h1, 32'({lines[PAS], lines[RDY]} == 2'b11));
    apb(1'b0, tcsp_pkg::TCSP_COUNT_OFS, 32'h0);
    chk("count", 32'h1, rd);
    repeat (PASSC + 4) @(posedge pclk);
    chk("pass over", 32'h0, 32'(lines[PAS]));
    $display("test pass done");
    i_tcsp_ctrl_model.pulse(RSTA);
    chk("jack start", 32'h1, 32'(lines[ACT]));
    n = rec_cnt;
    i_tcsp_ctrl_model.put_select(bcd(42));
    i_tcsp_ctrl_model.pulse(STB);
    chk("strobe in test", 32'(n), 32'(rec_cnt));
    judge_out(1'b0, 1'b1, 1'b0);
    chk("upper", 32'h1, 32'({lines[UPF], lines[RDY]} == 2'b10));
    i_tcsp_ctrl_model.pulse(RSTO);
    chk("jack stop", 32'h1, 32'({lines[UPF], lines[RDY]} == 2'b01));
    i_tcsp_ctrl_model.pulse(PSTA);
    chk("panel start ignored", 32'h0, 32'(lines[ACT]));
    i_tcsp_ctrl_model.pulse(STA);
    judge_out(1'b0, 1'b0, 1'b1);
    chk("lower", 32'h1, 32'(lines[LOF]));
    i_tcsp_ctrl_model.pulse(STO);
    chk("port stop", 32'h1, 32'({lines[LOF], lines[RDY]} == 2'b01));
    $display("test fail done");
    apb(1'b1, tcsp_pkg::TCSP_CTRL_OFS, 32'h1);
    i_tcsp_ctrl_model.pulse(STA);
    judge_out(1'b1, 1'b0, 1'b0);
    repeat (3 * PASSC) @(posedge pclk);
    chk("pass hold", 32'h1, 32'(lines[PAS]));
    apb(1'b1, tcsp_pkg::TCSP_CTRL_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    chk("soft stop", 32'h1, 32'({lines[PAS], lines[RDY]} == 2'b01));
    $display("test hold done");
    i_tcsp_ctrl_model.set_enable(1'b0);
    repeat (4 * DEB) @(posedge pclk);
    chk("enable change", 32'h1, 32'(lines[PRT]));
    i_tcsp_ctrl_model.pulse(PSTO);
    chk("panel stop clears", 32'h0, 32'(lines[PRT]));
    i_tcsp_ctrl_model.pulse(PSTA);
    chk("panel start", 32'h1, 32'(lines[ACT]));
    @(posedge pclk);
    core_trip <= 1'b1;
    repeat (3) @(posedge pclk);
    core_trip <= 1'b0;
    chk("trip", 32'h1, 32'(lines[PRT]));
    apb(1'b1, tcsp_pkg::TCSP_CTRL_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    chk("trip cleared", 32'h1, 32'({lines[PRT], lines[RDY]} == 2'b01));
    $display("test protect done");
    end_of_test();
  end
endmodule
